// file: include/crd_pkg.sv
// Package: constants, states and carriers for current detection and remote outputs.
package crd_pkg;
	// ********************************
	// Timing
	// ********************************
	localparam int unsigned CLK_PERIOD_NS = 25;
	localparam int unsigned TICK_MS = 10;
	localparam int unsigned TICK_CYC = TICK_MS * 1000000 / CLK_PERIOD_NS;
	localparam int unsigned RESP_MS = 100;
	localparam int unsigned ZC_HOLD_MS = 100;
	localparam logic [10:0] RESP_TICKS = 11'(RESP_MS / TICK_MS);
	localparam logic [3:0] ZC_HOLD_TICKS = 4'(ZC_HOLD_MS / TICK_MS);
	// ********************************
	// Settings, reset values and specials
	// ********************************
	localparam logic [7:0] HC_LEVEL_RST = 8'h78;
	localparam logic [9:0] HC_DELAY_RST = 10'h000;
	localparam logic [13:0] HC_HOLD_RST = 14'h000A;
	localparam logic [13:0] HOLD_KEEP = 14'h270F;
	localparam logic [7:0] ZC_LEVEL_RST = 8'h05;
	localparam logic [6:0] ZC_TIME_RST = 7'h32;
	localparam logic [3:0] RET_CLR = 4'h0;
	localparam logic [3:0] RET_SAVE = 4'h1;
	localparam logic [3:0] RET_KEEP_CLR = 4'hA;
	localparam logic [3:0] RET_KEEP_SAVE = 4'hB;
	localparam logic [11:0] REM_RST = 12'h000;
	// ********************************
	// Terminal function-select codes and bit positions
	// ********************************
	localparam logic [7:0] FS_HC_POS = 8'h0C;
	localparam logic [7:0] FS_HC_NEG = 8'h70;
	localparam logic [7:0] FS_ZC_POS = 8'h0D;
	localparam logic [7:0] FS_ZC_NEG = 8'h71;
	localparam logic [7:0] FS_REM_POS = 8'h60;
	localparam logic [7:0] FS_REM_NEG = 8'hC4;
	localparam int unsigned TERM_A_BIT = 0;
	localparam int unsigned TERM_B_BIT = 2;
	// ********************************
	// Types
	// ********************************
	typedef enum logic [1:0] {
		CRD_HC_IDLE = 2'b00,
		CRD_HC_ON = 2'b01,
		CRD_HC_HOLD = 2'b10,
		CRD_HC_LATCH = 2'b11
	} crd_hc_state_t;
	typedef struct packed {
		logic [7:0] high_current_level;
		logic [9:0] high_current_delay;
		logic [13:0] high_current_hold_time;
		logic high_current_trip_select;
		logic [7:0] zero_current_level;
		logic [6:0] zero_current_time;
		logic [3:0] remote_retention_mode;
		logic [7:0] terminal_function_select_a;
		logic [7:0] terminal_function_select_b;
	} crd_cfg_t;
endpackage : crd_pkg

// file: verilog/crd_current_remote.sv
// Current detectors, trip fault and remote output terminals of a motor drive.
`timescale 1ns/1ps
// How it works
// - Flag when current exceeds level while running.
// - High-current delay 0 to 10 s, default zero.
// - Flag retained for programmable hold time.
// - Hold 9999 keeps flag until next start.
// - Trip select 1 trips and raises fault.
// - After trip, hold time; 9999 until reset.
// - Trip select changed while flag on ignored.
// - Zero-current flag after current stays below level.
// - Zero-current flag held about 0.1 s.
// - Zero level of zero disables detection.
// - Detectors stay active during auto-tuning.
// - Flags respond with about 0.1 s latency.
// - Current flags reach terminals via codes 12/112/13/113.
// - Remote signal reaches terminals via codes 96/196.
// - Remote word is 12 bits, default zero.
// - Remote bit one drives terminal on, inverted negatively.
// - Modes 0/10 clear remote word at power-on.
// - Modes 1/11 save and restore word nonvolatile.
// - Modes 10/11 keep word through inverter reset.
// - Unassigned terminals ignore remote bits.
module crd_current_remote #(
	parameter int unsigned TICK_CYCLES = crd_pkg::TICK_CYC
) (
	// Clock and power-on reset
	input wire logic clock_in,
	input wire logic rst_b_in,
	// Drive status and events
	input wire logic running_in,
	input wire logic autotune_in,
	input wire logic start_in,
	input wire logic inv_reset_in,
	input wire logic power_fail_in,
	input wire logic [7:0] current_pct_in,
	// Settings
	input crd_pkg::crd_cfg_t cfg_in,
	// Remote word access from the serial link
	input wire logic rem_wr_in,
	input wire logic [11:0] rem_wdata_in,
	output logic [11:0] rem_data_out,
	// Nonvolatile store
	input wire logic [11:0] nvm_data_in,
	output logic nvm_save_out,
	output logic [11:0] nvm_data_out,
	// Flags, fault and terminals
	input wire logic [1:0] term_other_in,
	output logic high_current_flag_out,
	output logic zero_current_flag_out,
	output logic current_detect_trip_fault_out,
	output logic term_a_out,
	output logic term_b_out
);
	import crd_pkg::*;

	// ********************************
	// Functions
	// ********************************
	function automatic logic [10:0] qual_next(input logic cond, input logic tick,
		input logic [10:0] cnt, input logic [10:0] target);
		if (!cond)
			qual_next = 11'h000;
		else if (tick && (cnt < target))
			qual_next = 11'(cnt + 11'h001);
		else
			qual_next = cnt;
	endfunction : qual_next

	function automatic logic term_level(input logic [7:0] sel, input logic hc,
		input logic zc, input logic remote_output_signal, input logic other);
		unique case (sel)
			FS_HC_POS: term_level = hc;
			FS_HC_NEG: term_level = !hc;
			FS_ZC_POS: term_level = zc;
			FS_ZC_NEG: term_level = !zc;
			FS_REM_POS: term_level = remote_output_signal;
			FS_REM_NEG: term_level = !remote_output_signal;
			default: term_level = other;
		endcase
	endfunction : term_level

	// ********************************
	// Time base
	// ********************************
	logic [18:0] tick_cnt_ff;
	logic tick;
	assign tick = (tick_cnt_ff == 19'(TICK_CYCLES - 1));

	always_ff @(posedge clock_in)
	begin
		if (!rst_b_in || tick)
			tick_cnt_ff <= 19'h00000;
		else
			tick_cnt_ff <= 19'(tick_cnt_ff + 19'h00001);
	end

	// ********************************
	// Qualification timers
	// ********************************
	// Auto-tuning counts as running, so both detectors keep watching then.
	logic active;
	logic hc_cond;
	logic zc_cond;
	logic [10:0] hc_target;
	logic [10:0] zc_target;
	logic [10:0] hc_qual_ff;
	logic [10:0] zc_qual_ff;
	logic hc_qual;
	logic zc_qual;
	assign active = running_in || autotune_in;
	assign hc_cond = active && (current_pct_in > cfg_in.high_current_level);
	assign zc_cond = active && (cfg_in.zero_current_level != 8'h00) &&
		(current_pct_in < cfg_in.zero_current_level);
	// The fixed response latency rides on top of the programmed delay.
	assign hc_target = 11'(cfg_in.high_current_delay + RESP_TICKS);
	assign zc_target = 11'(cfg_in.zero_current_time + RESP_TICKS);
	assign hc_qual = hc_cond && (hc_qual_ff >= hc_target);
	assign zc_qual = zc_cond && (zc_qual_ff >= zc_target);

	always_ff @(posedge clock_in)
	begin
		if (!rst_b_in || inv_reset_in)
		begin
			hc_qual_ff <= 11'h000;
			zc_qual_ff <= 11'h000;
		end
		else
		begin
			hc_qual_ff <= qual_next(hc_cond, tick, hc_qual_ff, hc_target);
			zc_qual_ff <= qual_next(zc_cond, tick, zc_qual_ff, zc_target);
		end
	end

	// ********************************
	// High-current flag
	// ********************************
	crd_hc_state_t hc_state_ff;
	crd_hc_state_t nxt_hc_state;
	logic [13:0] hc_hold_ff;
	logic [13:0] nxt_hc_hold;
	logic fault_ff;
	logic fault_set;

	always_comb
	begin
		nxt_hc_state = hc_state_ff;
		nxt_hc_hold = hc_hold_ff;
		unique case (hc_state_ff)
			CRD_HC_IDLE:
			begin
				if (hc_qual)
					nxt_hc_state = CRD_HC_ON;
			end
			CRD_HC_ON:
			begin
				if (!hc_qual)
				begin
					if (cfg_in.high_current_hold_time == HOLD_KEEP)
						nxt_hc_state = CRD_HC_LATCH;
					else if (cfg_in.high_current_hold_time == 14'h0000)
						nxt_hc_state = CRD_HC_IDLE;
					else
					begin
						nxt_hc_state = CRD_HC_HOLD;
						nxt_hc_hold = cfg_in.high_current_hold_time;
					end
				end
			end
			CRD_HC_HOLD:
			begin
				if (hc_qual)
					nxt_hc_state = CRD_HC_ON;
				else if (tick)
				begin
					nxt_hc_hold = 14'(hc_hold_ff - 14'h0001);
					if (hc_hold_ff <= 14'h0001)
						nxt_hc_state = CRD_HC_IDLE;
				end
			end
			CRD_HC_LATCH:
			begin
				// A trip holds the flag until a reset, not until a start.
				if (start_in && !fault_ff)
					nxt_hc_state = CRD_HC_IDLE;
			end
		endcase
	end

	always_ff @(posedge clock_in)
	begin
		if (!rst_b_in || inv_reset_in)
		begin
			hc_state_ff <= CRD_HC_IDLE;
			hc_hold_ff <= 14'h0000;
		end
		else
		begin
			hc_state_ff <= nxt_hc_state;
			hc_hold_ff <= nxt_hc_hold;
		end
	end

	// Trip select is sampled only on the rising flag, so a late change waits.
	assign fault_set = (hc_state_ff == CRD_HC_IDLE) && hc_qual &&
		cfg_in.high_current_trip_select;

	always_ff @(posedge clock_in)
	begin
		if (!rst_b_in)
			fault_ff <= 1'b0;
		else
			fault_ff <= fault_set || (fault_ff && !inv_reset_in);
	end

	// ********************************
	// Zero-current flag
	// ********************************
	logic [3:0] zc_hold_ff;
	logic zc_flag_ff;

	always_ff @(posedge clock_in)
	begin
		if (!rst_b_in || inv_reset_in)
			zc_hold_ff <= 4'h0;
		else if (zc_qual)
			zc_hold_ff <= ZC_HOLD_TICKS;
		else if (tick && (zc_hold_ff != 4'h0))
			zc_hold_ff <= 4'(zc_hold_ff - 4'h1);
	end

	always_ff @(posedge clock_in)
	begin
		if (!rst_b_in || inv_reset_in)
			zc_flag_ff <= 1'b0;
		else
			zc_flag_ff <= zc_qual || (zc_hold_ff != 4'h0);
	end

	// ********************************
	// Remote output word
	// ********************************
	logic [11:0] rem_bits_ff;
	logic restore_ff;
	logic mode_save;
	logic mode_keep;
	assign mode_save = (cfg_in.remote_retention_mode == RET_SAVE) ||
		(cfg_in.remote_retention_mode == RET_KEEP_SAVE);
	assign mode_keep = (cfg_in.remote_retention_mode == RET_KEEP_CLR) ||
		(cfg_in.remote_retention_mode == RET_KEEP_SAVE);

	// The stored word is read one cycle after release, never under reset.
	always_ff @(posedge clock_in)
	begin
		if (!rst_b_in)
			restore_ff <= 1'b1;
		else
			restore_ff <= 1'b0;
	end

	always_ff @(posedge clock_in)
	begin
		if (!rst_b_in)
			rem_bits_ff <= REM_RST;
		else if (restore_ff)
			rem_bits_ff <= mode_save ? nvm_data_in : REM_RST;
		else if (inv_reset_in && !mode_keep)
			rem_bits_ff <= REM_RST;
		else if (rem_wr_in)
			rem_bits_ff <= rem_wdata_in;
	end

	// Only a power failure saves; inverter resets never touch the store.
	always_ff @(posedge clock_in)
	begin
		if (!rst_b_in)
		begin
			nvm_save_out <= 1'b0;
			nvm_data_out <= REM_RST;
		end
		else
		begin
			nvm_save_out <= power_fail_in && mode_save;
			if (power_fail_in && mode_save)
				nvm_data_out <= rem_bits_ff;
		end
	end

	// ********************************
	// Terminals
	// ********************************
	always_ff @(posedge clock_in)
	begin
		if (!rst_b_in)
		begin
			term_a_out <= 1'b0;
			term_b_out <= 1'b0;
		end
		else
		begin
			term_a_out <= term_level(cfg_in.terminal_function_select_a,
				high_current_flag_out, zc_flag_ff, rem_bits_ff[TERM_A_BIT],
				term_other_in[0]);
			term_b_out <= term_level(cfg_in.terminal_function_select_b,
				high_current_flag_out, zc_flag_ff, rem_bits_ff[TERM_B_BIT],
				term_other_in[1]);
		end
	end

	assign high_current_flag_out = (hc_state_ff != CRD_HC_IDLE);
	assign zero_current_flag_out = zc_flag_ff;
	assign current_detect_trip_fault_out = fault_ff;
	assign rem_data_out = rem_bits_ff;

	// ********************************
	// Assertions
	// ********************************
	default clocking cb @(posedge clock_in); endclocking
	default disable iff (!rst_b_in);

	sequence s_hc_rise;
		!high_current_flag_out ##1 high_current_flag_out;
	endsequence
	sequence s_zc_rise;
		!zc_flag_ff ##1 zc_flag_ff;
	endsequence

	hc_qualified_a: assert property (s_hc_rise |-> $past(hc_qual))
		else $error("High-current flag rose without qualification.");
	hc_delay_a: assert property (hc_qual |-> hc_qual_ff >= 11'(RESP_TICKS))
		else $error("High-current qualification shorter than latency.");
	hc_hold_a: assert property ((hc_state_ff == CRD_HC_HOLD) && !tick && !inv_reset_in
		|=> high_current_flag_out)
		else $error("High-current flag dropped inside hold time.");
	hc_latch_a: assert property ((hc_state_ff == CRD_HC_LATCH) && !start_in && !inv_reset_in
		|=> high_current_flag_out)
		else $error("Latched high-current flag dropped without start.");
	trip_gate_a: assert property ($rose(fault_ff) |-> $past(hc_state_ff == CRD_HC_IDLE)
		&& $past(cfg_in.high_current_trip_select) && high_current_flag_out)
		else $error("Trip fault raised without a fresh flag.");
	fault_latch_a: assert property (fault_ff && !inv_reset_in |=> fault_ff)
		else $error("Trip fault cleared without reset.");
	trip_late_a: assert property (high_current_flag_out && !fault_ff && !inv_reset_in
		|=> !fault_ff)
		else $error("Trip raised while flag already on.");
	zc_hold_time_a: assert property (s_zc_rise |-> zc_flag_ff[*8])
		else $error("Zero-current flag held too short.");
	zc_disable_a: assert property (s_zc_rise |->
		$past(cfg_in.zero_current_level) != 8'h00)
		else $error("Zero-current flag with detection disabled.");
	rem_write_a: assert property (rem_wr_in && !restore_ff && !inv_reset_in
		|=> rem_data_out == $past(rem_wdata_in))
		else $error("Remote word write lost.");
	rem_keep_a: assert property (inv_reset_in && !restore_ff && !rem_wr_in
		|=> rem_data_out == ($past(mode_keep) ? $past(rem_bits_ff) : REM_RST))
		else $error("Remote word wrong after inverter reset.");
	nvm_save_a: assert property (power_fail_in && mode_save
		|=> nvm_save_out && nvm_data_out == $past(rem_bits_ff))
		else $error("Remote word not saved at power-off.");
	term_rem_a: assert property (cfg_in.terminal_function_select_a == FS_REM_POS
		|=> term_a_out == $past(rem_bits_ff[TERM_A_BIT]))
		else $error("Terminal A not following its remote bit.");

endmodule : crd_current_remote

// file: tb/crd_term_nvm.sv
// Far-side model: nonvolatile store for the remote word and the other terminal functions.
`timescale 1ns/1ps
module crd_term_nvm (
	// Clock
	input wire logic clock_in,
	// Store access
	input wire logic save_in,
	input wire logic [11:0] data_in,
	output logic [11:0] stored_out,
	// Other terminal functions
	output logic [1:0] other_out
);
	initial stored_out = 12'h000;
	initial other_out = 2'h1;
	// The store keeps the word across any reset; only a save pulse changes it.
	always @(posedge clock_in)
	begin
		if (save_in)
			stored_out <= data_in;
	end
	// Toggling every clock exposes a terminal that shows a stale other function.
	always @(posedge clock_in)
	begin
		other_out <= ~other_out;
	end
endmodule : crd_term_nvm

// file: tb/crd_current_remote_test.sv
// Self-checking testbench for the current detectors and remote output terminals.
`timescale 1ns/1ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin failures++; \
	$display("[FAIL] %0t got %0h exp %0h", $time, a, b); end end
module crd_current_remote_test;
	import crd_pkg::*;
	// ********************************
	// Signals
	// ********************************
	localparam int TK = 4;
	logic clk = 0, rst_b = 0, run = 0, tune = 0, start = 0, inv = 0, pf = 0, wr = 0;
	logic [7:0] cur = 8'h00;
	logic [11:0] wdata = 12'h000, word, nvm_in, nvm_out, d;
	logic nsave, hcf, zcf, fault, ta, tb;
	logic [1:0] oth;
	crd_cfg_t cfg = '{HC_LEVEL_RST, HC_DELAY_RST, HC_HOLD_RST, 1'b0, ZC_LEVEL_RST,
		ZC_TIME_RST, RET_CLR, FS_REM_POS, FS_REM_NEG};
	logic [7:0] codes [7] = '{FS_REM_POS, FS_REM_NEG, FS_HC_POS, FS_HC_NEG, FS_ZC_POS,
		FS_ZC_NEG, 8'h01};
	int failures = 0, n_tests = 0, n;
	initial forever #12.5 clk = ~clk;
	crd_current_remote #(.TICK_CYCLES(TK)) u_dut (.clock_in(clk), .rst_b_in(rst_b),
		.running_in(run), .autotune_in(tune), .start_in(start), .inv_reset_in(inv),
		.power_fail_in(pf), .current_pct_in(cur), .cfg_in(cfg), .rem_wr_in(wr),
		.rem_wdata_in(wdata), .rem_data_out(word), .nvm_data_in(nvm_in),
		.nvm_save_out(nsave), .nvm_data_out(nvm_out), .term_other_in(oth),
		.high_current_flag_out(hcf), .zero_current_flag_out(zcf),
		.current_detect_trip_fault_out(fault), .term_a_out(ta), .term_b_out(tb));
	crd_term_nvm u_far (.clock_in(clk), .save_in(nsave), .data_in(nvm_out),
		.stored_out(nvm_in), .other_out(oth));
	// ********************************
	// Helpers
	// ********************************
	task automatic cyc(input int k);
		repeat (k) @(negedge clk);
	endtask : cyc
	task automatic host_write(input logic [11:0] v);
		wr = 1'b1;
		wdata = v;
		cyc(1);
		wr = 1'b0;
	endtask : host_write
	task automatic pulse_inv();
		inv = 1'b1;
		cyc(1);
		inv = 1'b0;
	endtask : pulse_inv
	task automatic wait_flag(input bit zc, input logic v, output int k);
		k = 0;
		while (((zc ? zcf : hcf) !== v) && k < 400)
		begin
			cyc(1);
			k++;
		end
	endtask : wait_flag
	// Tick phase is free running, so a count of ticks lands within one tick of slack.
	function automatic logic win(input int k, input int ticks);
		return (k >= (ticks - 1) * TK) && (k <= ticks * TK + 3);
	endfunction : win
	function automatic logic exp_term(input logic [7:0] c, input logic r, input logic o);
		case (c)
			FS_REM_POS: return r;
			FS_REM_NEG: return ~r;
			FS_HC_NEG, FS_ZC_NEG: return 1'b1;
			FS_HC_POS, FS_ZC_POS: return 1'b0;
			default: return o;
		endcase
	endfunction : exp_term
	task automatic hc_cycle(input int hold);
		cur = 8'd130;
		wait_flag(0, 1'b1, n);
		`CHK(win(n, 12), 1'b1)
		cur = 8'd50;
		wait_flag(0, 1'b0, n);
		`CHK(win(n, hold), 1'b1)
	endtask : hc_cycle
	task automatic conclude();
		if (failures == 0 && n_tests > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : conclude
	// ********************************
	// Tests
	// ********************************
	initial
	begin
		cyc(20000);
		failures++;
		conclude();
	end
	initial
	begin
		void'($urandom(32'h8991));
		cyc(16);
		rst_b = 1'b1;
		cyc(2);
		`CHK(word, REM_RST)
		for (int i = 0; i < 16; i++)
		begin
			cfg.terminal_function_select_a = codes[$urandom % 7];
			cfg.terminal_function_select_b = codes[$urandom % 7];
			d = 12'($urandom);
			host_write(d);
			`CHK(word, d)
			cyc(1);
			`CHK(ta, exp_term(cfg.terminal_function_select_a, d[0], ~oth[0]))
			`CHK(tb, exp_term(cfg.terminal_function_select_b, d[2], ~oth[1]))
		end
		cfg.terminal_function_select_a = FS_HC_POS;
		cfg.high_current_delay = 10'h002;
		cfg.high_current_hold_time = 14'h0005;
		cfg.zero_current_time = 7'h03;
		run = 1'b1;
		cur = 8'd120;
		cyc(80);
		`CHK(hcf, 1'b0)
		hc_cycle(5);
		cur = 8'd130;
		cyc(30);
		cur = 8'd50;
		cyc(2);
		cur = 8'd130;
		wait_flag(0, 1'b1, n);
		`CHK(win(n, 12), 1'b1)
		cyc(1);
		`CHK(ta, 1'b1)
		cur = 8'd50;
		wait_flag(0, 1'b0, n);
		cfg.high_current_trip_select = 1'b1;
		hc_cycle(5);
		`CHK(fault, 1'b1)
		pulse_inv();
		cyc(1);
		`CHK(fault, 1'b0)
		cfg.high_current_trip_select = 1'b0;
		cur = 8'd130;
		wait_flag(0, 1'b1, n);
		cfg.high_current_trip_select = 1'b1;
		cyc(3);
		`CHK(fault, 1'b0)
		cur = 8'd50;
		wait_flag(0, 1'b0, n);
		cfg.high_current_trip_select = 1'b0;
		cfg.high_current_hold_time = HOLD_KEEP;
		cur = 8'd130;
		wait_flag(0, 1'b1, n);
		cur = 8'd50;
		cyc(100);
		`CHK(hcf, 1'b1)
		start = 1'b1;
		cyc(1);
		start = 1'b0;
		cyc(1);
		`CHK(hcf, 1'b0)
		cfg.high_current_trip_select = 1'b1;
		cur = 8'd130;
		wait_flag(0, 1'b1, n);
		cur = 8'd50;
		cyc(2);
		start = 1'b1;
		cyc(1);
		start = 1'b0;
		cyc(2);
		`CHK(hcf, 1'b1)
		pulse_inv();
		cyc(1);
		`CHK(hcf, 1'b0)
		run = 1'b0;
		tune = 1'b1;
		cur = 8'd2;
		wait_flag(1, 1'b1, n);
		`CHK(win(n, 13), 1'b1)
		cur = 8'd50;
		wait_flag(1, 1'b0, n);
		`CHK(win(n, 10), 1'b1)
		cfg.zero_current_level = 8'h00;
		cur = 8'd0;
		cyc(120);
		`CHK(zcf, 1'b0)
		tune = 1'b0;
		for (int m = 0; m < 3; m++)
		begin
			cfg.remote_retention_mode = (m == 0) ? RET_CLR :
				((m == 1) ? RET_KEEP_CLR : RET_KEEP_SAVE);
			d = 12'($urandom) | 12'h001;
			host_write(d);
			pulse_inv();
			cyc(1);
			`CHK(word, m ? d : 12'h000)
		end
		cfg.remote_retention_mode = RET_SAVE;
		d = 12'($urandom) | 12'h800;
		host_write(d);
		pf = 1'b1;
		cyc(1);
		pf = 1'b0;
		`CHK(nsave, 1'b1)
		`CHK(nvm_out, d)
		cyc(3);
		`CHK(nvm_in, d)
		host_write(~d);
		pulse_inv();
		cyc(3);
		`CHK(nvm_in, d)
		rst_b = 1'b0;
		cyc(2);
		rst_b = 1'b1;
		cyc(3);
		`CHK(word, d)
		cfg.remote_retention_mode = RET_KEEP_CLR;
		rst_b = 1'b0;
		cyc(2);
		rst_b = 1'b1;
		cyc(3);
		`CHK(word, 12'h000)
		conclude();
	end
endmodule : crd_current_remote_test
